// File: osc_ctrl.sv
// Purpose: APB register bank of an oscillator controller with interrupt logic.
// Assumes: One clock; status and protection inputs come from other clock domains.
// Notes:   Analog loops are outside; their status arrives on src_status.
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl
  import osc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [31:0] src_status,
  input  wire logic        peripheral_access_guard,
  input  wire logic [31:0] fll_value_in,
  input  wire logic [1:0]  pll_lock_status,
  output logic             irq,
  output logic [15:0]      crystal_osc_control,
  output logic [7:0]       internal_rc_osc_control,
  output logic [15:0]      fll_control,
  output logic [31:0]      fll_multiplier,
  output logic [7:0]       pll_control_a,
  output logic [31:0]      pll_ratio,
  output logic [31:0]      pll_control_b,
  output logic [7:0]       pll_output_divider
);
  import osc_pkg::*;

  typedef enum logic [1:0] {OSC_IDLE, OSC_SYNC, OSC_DONE} osc_state_t;

  logic [31:0]           status_meta;
  logic [31:0]           status_sync;
  logic [31:0]           status_prev;
  logic [1:0]            guard_meta;
  logic                  guard_sync;
  logic [1:0]            lock_meta;
  logic [1:0]            lock_sync;
  logic [31:0]           irq_enable;
  logic [31:0]           irq_flags;
  logic [31:0]           fll_value;
  logic [31:0]           fll_value_meta;
  logic [31:0]           fll_value_sync;
  logic [7:0]            fll_read_sync;
  logic [7:0]            pll_sync_busy;
  logic [SYNC_CNT_W-1:0] sync_cnt;
  osc_state_t            state;
  osc_state_t            next_state;
  logic [31:0]           wmask;
  logic [31:0]           rdata;
  logic                  access;
  logic                  needs_sync;
  logic                  commit;
  logic                  wr;
  logic                  wr_allowed;
  logic [31:0]           fll_value_prev;
  logic                  fll_value_steady;
  logic                  fll_capture_wait;

  // Byte strobes widen to a bit mask so 8- and 16-bit parts can be written alone.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  assign access = psel && penable;

  // Value, control and multiplier of the loop and the PLL ratio, divider and control A pass a sync step first.
  always_comb begin
    needs_sync = (paddr == OFS_FLL_VALUE) || (paddr == OFS_FLL_MULTIPLIER) ||
                 (paddr == OFS_FLL_CONTROL) || (paddr == OFS_PLL_RATIO) ||
                 (paddr == OFS_PLL_OUTPUT_DIVIDER) || (paddr == OFS_PLL_CONTROL_A);
  end

  always_comb begin
    next_state = state;
    case (state)
      OSC_IDLE: begin
        if (access) begin
          next_state = needs_sync ? OSC_SYNC : OSC_DONE;
        end
      end
      OSC_SYNC: begin
        if (sync_cnt == SYNC_CNT_W'(SYNC_CYCLES - 1)) begin
          next_state = OSC_DONE;
        end
      end
      OSC_DONE: next_state = OSC_IDLE;
      default:  next_state = OSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state    <= OSC_IDLE;
      sync_cnt <= '0;
    end else begin
      state    <= next_state;
      sync_cnt <= (state == OSC_SYNC) ? sync_cnt + 1'b1 : '0;
    end
  end

  assign commit = (state == OSC_DONE);
  assign wr     = commit && pwrite;

  // Inputs from other domains pass two flip-flops before any logic reads them.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_meta <= '0;
      status_sync <= '0;
      status_prev <= '0;
    end else begin
      status_meta <= src_status;
      status_sync <= status_meta;
      status_prev <= status_sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      guard_meta <= '0;
    end else begin
      guard_meta <= {guard_meta[0], peripheral_access_guard};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lock_meta <= '0;
      lock_sync <= '0;
    end else begin
      lock_meta <= pll_lock_status;
      lock_sync <= lock_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_value_meta <= '0;
      fll_value_sync <= '0;
      fll_value_prev <= '0;
    end else begin
      fll_value_meta <= fll_value_in;
      fll_value_sync <= fll_value_meta;
      fll_value_prev <= fll_value_sync;
    end
  end

  // A word synced bit by bit may tear in mid-change; two equal samples mean it is whole.
  assign fll_value_steady = (fll_value_sync == fll_value_prev);

  assign guard_sync = guard_meta[1];

  // Shared enable state behind both set and clear offsets; guarded writes drop.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_enable <= RESET_ZERO;
    end else if (wr && !guard_sync) begin
      if (paddr == OFS_IRQ_ENABLE_SET) begin
        irq_enable <= irq_enable | (pwdata & wmask & IRQ_SOURCE_MASK);
      end else if (paddr == OFS_IRQ_ENABLE_CLEAR) begin
        irq_enable <= irq_enable & ~(pwdata & wmask & IRQ_SOURCE_MASK);
      end
    end
  end

  // A rising edge that coincides with a clear still leaves the flag set.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_flags <= RESET_ZERO;
    end else begin
      irq_flags <= ((wr && paddr == OFS_IRQ_FLAGS) ?
                    irq_flags & ~(pwdata & wmask) : irq_flags) |
                   (status_sync & ~status_prev & IRQ_SOURCE_MASK);
    end
  end

  // Per-source enables sit at their fixed bits.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_enable & irq_flags & IRQ_SOURCE_MASK);
    end
  end

  // Control registers; the access guard covers them like the enables.
  assign wr_allowed = wr && !guard_sync;

  // Strobed lanes take new data on writable bits; all other bits keep their value.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [31:0] lanes,
                                             input logic [31:0] writable);
    lane_merge = (old_val & ~(lanes & writable)) | (new_val & lanes & writable);
  endfunction : lane_merge

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      crystal_osc_control <= '0;
    end else if (wr_allowed && paddr == OFS_CRYSTAL_OSC_CTRL) begin
      crystal_osc_control <= 16'(lane_merge({16'h0000, crystal_osc_control}, pwdata,
                                             wmask, MASK_CRYSTAL_CTRL));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      internal_rc_osc_control <= '0;
    end else if (wr_allowed && paddr == OFS_INTERNAL_RC_CTRL) begin
      internal_rc_osc_control <= 8'(lane_merge({24'h000000, internal_rc_osc_control},
                                               pwdata, wmask, MASK_INTERNAL_RC_CTRL));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_control <= '0;
    end else if (wr_allowed && paddr == OFS_FLL_CONTROL) begin
      fll_control <= 16'(lane_merge({16'h0000, fll_control}, pwdata, wmask,
                                     MASK_FLL_CONTROL));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_multiplier <= '0;
    end else if (wr_allowed && paddr == OFS_FLL_MULTIPLIER) begin
      fll_multiplier <= lane_merge(fll_multiplier, pwdata, wmask, '1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_control_a <= '0;
    end else if (wr_allowed && paddr == OFS_PLL_CONTROL_A) begin
      pll_control_a <= 8'(lane_merge({24'h000000, pll_control_a}, pwdata, wmask,
                                     MASK_PLL_CONTROL_A));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_ratio <= '0;
    end else if (wr_allowed && paddr == OFS_PLL_RATIO) begin
      pll_ratio <= lane_merge(pll_ratio, pwdata, wmask,
                              MASK_PLL_RATIO);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_control_b <= '0;
    end else if (wr_allowed && paddr == OFS_PLL_CONTROL_B) begin
      pll_control_b <= lane_merge(pll_control_b, pwdata, wmask,
                                  MASK_PLL_CONTROL_B);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_output_divider <= '0;
    end else if (wr_allowed && paddr == OFS_PLL_OUTPUT_DIVIDER) begin
      pll_output_divider <= 8'(lane_merge({24'h000000, pll_output_divider}, pwdata, wmask,
                                          MASK_PLL_OUTPUT_DIV));
    end
  end

  // The read request is a one-cycle strobe, so software always reads it back as zero.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_read_sync <= '0;
    end else if (wr_allowed && paddr == OFS_FLL_READ_SYNC) begin
      fll_read_sync <= 8'(pwdata & wmask & MASK_FLL_READ_SYNC);
    end else begin
      fll_read_sync <= '0;
    end
  end

  // A request that meets a moving loop value waits here until the value holds still.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_capture_wait <= 1'b0;
    end else begin
      fll_capture_wait <= (fll_capture_wait || fll_read_sync[7]) && !fll_value_steady;
    end
  end

  // A software write wins over a capture that falls in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fll_value <= '0;
    end else if (wr_allowed && paddr == OFS_FLL_VALUE) begin
      fll_value <= lane_merge(fll_value, pwdata, wmask, '1);
    end else if ((fll_read_sync[7] || fll_capture_wait) && fll_value_steady) begin
      fll_value <= fll_value_sync;
    end
  end

  // Busy bits show a PLL write that is still in its sync step.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pll_sync_busy <= '0;
    end else begin
      pll_sync_busy <= '0;
      if (state == OSC_SYNC && pwrite) begin
        pll_sync_busy[PLL_SYNC_ENABLE]  <= (paddr == OFS_PLL_CONTROL_A);
        pll_sync_busy[PLL_SYNC_RATIO]   <= (paddr == OFS_PLL_RATIO);
        pll_sync_busy[PLL_SYNC_DIVIDER] <= (paddr == OFS_PLL_OUTPUT_DIVIDER);
      end
    end
  end

  // Unmapped offsets and reserved bits read as zero.
  always_comb begin
    case (paddr)
      OFS_IRQ_ENABLE_CLEAR:   rdata = irq_enable;
      OFS_IRQ_ENABLE_SET:     rdata = irq_enable;
      OFS_IRQ_FLAGS:          rdata = irq_flags;
      OFS_OSC_STATUS:         rdata = status_sync & IRQ_SOURCE_MASK;
      OFS_CRYSTAL_OSC_CTRL:   rdata = {16'h0000, crystal_osc_control};
      OFS_INTERNAL_RC_CTRL:   rdata = {24'h000000, internal_rc_osc_control};
      OFS_FLL_CONTROL:        rdata = {16'h0000, fll_control};
      OFS_FLL_VALUE:          rdata = fll_value;
      OFS_FLL_MULTIPLIER:     rdata = fll_multiplier;
      OFS_FLL_READ_SYNC:      rdata = {24'h000000, fll_read_sync};
      OFS_PLL_CONTROL_A:      rdata = {24'h000000, pll_control_a};
      OFS_PLL_RATIO:          rdata = pll_ratio;
      OFS_PLL_CONTROL_B:      rdata = pll_control_b;
      OFS_PLL_OUTPUT_DIVIDER: rdata = {24'h000000, pll_output_divider};
      OFS_PLL_SYNC_BUSY:      rdata = {24'h000000, pll_sync_busy};
      OFS_PLL_STATUS:         rdata = {30'h00000000, lock_sync};
      default:                rdata = 32'h0000_0000;
    endcase
  end

  // Answer is registered; a guarded or unmapped access still completes without error.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= (next_state == OSC_DONE);
      prdata  <= (next_state == OSC_DONE && !pwrite) ? rdata : '0;
      pslverr <= 1'b0;
    end
  end

endmodule : osc_ctrl
`default_nettype wire

// File: osc_ctrl_checker.sv
// Purpose: Port-level assertions for the oscillator controller bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The guard is synced in two stages, so it is trusted after four stable cycles.
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl_checker
  import osc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        peripheral_access_guard,
  input wire logic        irq,
  input wire logic [15:0] crystal_osc_control,
  input wire logic [31:0] pll_control_b
);
  logic       g_last;
  logic [2:0] g_cnt;
  logic       wr_open;
  logic       wr_shut;
  logic       rd_done;
  always_ff @(posedge sys_clk) begin
    g_last <= peripheral_access_guard;
    if (!rstn || peripheral_access_guard != g_last) begin
      g_cnt <= 3'h0;
    end else if (g_cnt != 3'h7) begin
      g_cnt <= g_cnt + 3'h1;
    end
  end
  assign wr_open = pready && pwrite && !peripheral_access_guard && g_cnt > 3'h3;
  assign wr_shut = pready && pwrite && peripheral_access_guard && g_cnt > 3'h3;
  assign rd_done = pready && !pwrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  chk_no_error: assert property (!pslverr) else $error("pslverr raised");
  chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a single access pulse");
  chk_ready_bound: assert property (s_setup |-> ##[0:6] pready)
    else $error("transfer not answered in time");
  chk_idle_rdata: assert property (!pready |-> prdata == RESET_ZERO)
    else $error("read data outside a read answer");
  chk_irq_bits: assert property (rd_done && paddr <= OFS_OSC_STATUS |->
    (prdata & ~IRQ_SOURCE_MASK) == RESET_ZERO) else $error("unassigned bit reads one");
  chk_crystal_width: assert property (rd_done && paddr == OFS_CRYSTAL_OSC_CTRL |->
    prdata == {16'h0, crystal_osc_control}) else $error("16-bit register read wrong");
  chk_byte_lane: assert property (wr_open && paddr == OFS_CRYSTAL_OSC_CTRL && pstrb == 4'h2
    |=> crystal_osc_control == {$past(pwdata[15:8]) & 8'hf7, $past(crystal_osc_control[7:0])})
    else $error("byte lane write wrong");
  chk_guard_hold: assert property (wr_shut && paddr == OFS_PLL_CONTROL_B |=>
    $stable(pll_control_b)) else $error("protected write took effect");
  chk_clear_irq: assert property (wr_open && paddr == OFS_IRQ_ENABLE_CLEAR &&
    pstrb == 4'hf && pwdata == 32'hffff_ffff |-> ##2 !irq) else $error("irq after full clear");
endmodule : osc_ctrl_checker
bind osc_ctrl osc_ctrl_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
  .peripheral_access_guard(peripheral_access_guard),
  .crystal_osc_control(crystal_osc_control), .pll_control_b(pll_control_b));
`default_nettype wire

// File: osc_pkg.sv
// Purpose: Constants for the oscillator controller register bank.
// Assumes: 32-bit APB data, byte addresses are the printed offsets.
// Notes:   Source bit positions are shared by enable, flag and status.
package osc_pkg;
  localparam logic [7:0]  OFS_IRQ_ENABLE_CLEAR   = 8'h00;
  localparam logic [7:0]  OFS_IRQ_ENABLE_SET     = 8'h04;
  localparam logic [7:0]  OFS_IRQ_FLAGS          = 8'h08;
  localparam logic [7:0]  OFS_OSC_STATUS         = 8'h0c;
  localparam logic [7:0]  OFS_CRYSTAL_OSC_CTRL   = 8'h10;
  localparam logic [7:0]  OFS_INTERNAL_RC_CTRL   = 8'h14;
  localparam logic [7:0]  OFS_FLL_CONTROL        = 8'h18;
  localparam logic [7:0]  OFS_FLL_VALUE          = 8'h1c;
  localparam logic [7:0]  OFS_FLL_MULTIPLIER     = 8'h20;
  localparam logic [7:0]  OFS_FLL_READ_SYNC      = 8'h24;
  localparam logic [7:0]  OFS_PLL_CONTROL_A      = 8'h28;
  localparam logic [7:0]  OFS_PLL_RATIO          = 8'h2c;
  localparam logic [7:0]  OFS_PLL_CONTROL_B      = 8'h30;
  localparam logic [7:0]  OFS_PLL_OUTPUT_DIVIDER = 8'h34;
  localparam logic [7:0]  OFS_PLL_SYNC_BUSY      = 8'h38;
  localparam logic [7:0]  OFS_PLL_STATUS         = 8'h3c;
  localparam int          BIT_CRYSTAL_READY      = 0;
  localparam int          BIT_INTERNAL_RC_READY  = 4;
  localparam int          BIT_FLL_READY          = 8;
  localparam int          BIT_FLL_OUT_OF_BOUNDS  = 9;
  localparam int          BIT_FLL_FINE_LOCK      = 10;
  localparam int          BIT_FLL_COARSE_LOCK    = 11;
  localparam int          BIT_FLL_REF_STOPPED    = 12;
  localparam int          BIT_PLL_LOCK_RISE      = 16;
  localparam int          BIT_PLL_LOCK_FALL      = 17;
  localparam int          BIT_PLL_LOCK_TIMEOUT   = 18;
  localparam int          BIT_PLL_RATIO_DONE     = 19;
  localparam logic [31:0] IRQ_SOURCE_MASK        = 32'h000f_1f11;
  localparam logic [31:0] MASK_CRYSTAL_CTRL      = 32'h0000_f7c6;
  localparam logic [31:0] MASK_INTERNAL_RC_CTRL  = 32'h0000_00ce;
  localparam logic [31:0] MASK_FLL_CONTROL       = 32'h0000_0ffe;
  localparam logic [31:0] MASK_PLL_CONTROL_A     = 32'h0000_00c2;
  localparam logic [31:0] MASK_PLL_RATIO         = 32'h000f_0fff;
  localparam logic [31:0] MASK_PLL_CONTROL_B     = 32'h07ff_173f;
  localparam logic [31:0] MASK_PLL_OUTPUT_DIV    = 32'h0000_0003;
  localparam logic [31:0] MASK_FLL_READ_SYNC     = 32'h0000_0080;
  localparam logic [31:0] RESET_ZERO             = 32'h0000_0000;
  localparam int          SYNC_CYCLES            = 3;
  localparam int          SYNC_CNT_W             = 2;
  localparam int          PLL_SYNC_ENABLE        = 1;
  localparam int          PLL_SYNC_RATIO         = 2;
  localparam int          PLL_SYNC_DIVIDER       = 3;
  localparam int          FLL_ENABLE_BIT         = 1;
endpackage : osc_pkg

// File: tb_oscillator_ctrl_register_map.sv
// Purpose: Self-checking bench for the oscillator controller bank.
// Assumes: APB master on one 100 MHz clock.
// Notes:   Flag latency is a few cycles, so waits before flag reads are fixed.
`timescale 1ns/100ps
`default_nettype none
module tb_oscillator_ctrl_register_map;
  import osc_pkg::*;
  logic        sys_clk, rstn, psel, penable, pwrite, guard, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, src, rd;
  logic [15:0] fl_ctl;
  logic [7:0]  rc_ctl, pa_ctl, pdiv;
  logic [31:0] fmul, prat;
  int          fails, n_checks;
  always #5 sys_clk = ~sys_clk;
  osc_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .src_status(src), .peripheral_access_guard(guard),
    .fll_value_in(32'h1234_5678), .pll_lock_status(2'h1), .irq(irq),
    .crystal_osc_control(), .internal_rc_osc_control(rc_ctl), .fll_control(fl_ctl),
    .fll_multiplier(fmul), .pll_control_a(pa_ctl), .pll_ratio(prat), .pll_control_b(),
    .pll_output_divider(pdiv));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", w, e, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      give_verdict();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("reg %h", a), rd, e);
  endtask : rdchk
  task automatic irq_is(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 12) begin
      @(posedge sys_clk);
      n++;
    end
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irq_is
  task automatic t_enable;
    apb(1'b1, OFS_IRQ_ENABLE_SET, 32'hffff_ffff, 4'hf);
    rdchk(OFS_IRQ_ENABLE_SET, 32'h000f_1f11);
    apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0, 4'hf);
    rdchk(OFS_IRQ_ENABLE_CLEAR, 32'h000f_1f11);
    apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0008_0001, 4'hf);
    rdchk(OFS_IRQ_ENABLE_SET, 32'h0007_1f10);
    apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'hffff_ffff, 4'hf);
    rdchk(OFS_IRQ_ENABLE_SET, 32'h0);
  endtask : t_enable
  task automatic t_sources;
    int          bits[11] = '{0, 4, 8, 9, 10, 11, 12, 16, 17, 18, 19};
    logic [31:0] m;
    foreach (bits[i]) begin
      m = 32'h1 << bits[i];
      src <= m;
      repeat (6) @(posedge sys_clk);
      rdchk(OFS_IRQ_FLAGS, m);
      rdchk(OFS_OSC_STATUS, m);
      irq_is(1'b0);
      apb(1'b1, OFS_IRQ_ENABLE_SET, m, 4'hf);
      irq_is(1'b1);
      apb(1'b1, OFS_IRQ_FLAGS, 32'h0, 4'hf);
      rdchk(OFS_IRQ_FLAGS, m);
      apb(1'b1, OFS_IRQ_ENABLE_CLEAR, m, 4'hf);
      irq_is(1'b0);
      apb(1'b1, OFS_IRQ_FLAGS, m, 4'hf);
      rdchk(OFS_IRQ_FLAGS, 32'h0);
      src <= 32'h0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : t_sources
  task automatic t_lanes;
    apb(1'b1, OFS_IRQ_ENABLE_SET, 32'hffff_ffff, 4'h4);
    rdchk(OFS_IRQ_ENABLE_SET, 32'h000f_0000);
    apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFS_CRYSTAL_OSC_CTRL, 32'hffff_ffff, 4'h2);
    rdchk(OFS_CRYSTAL_OSC_CTRL, 32'h0000_f700);
    apb(1'b1, OFS_CRYSTAL_OSC_CTRL, 32'hffff_ffff, 4'h1);
    rdchk(OFS_CRYSTAL_OSC_CTRL, 32'h0000_f7c6);
    apb(1'b1, OFS_PLL_RATIO, 32'hffff_ffff, 4'hf);
    rdchk(OFS_PLL_RATIO, 32'h000f_0fff);
    apb(1'b1, OFS_FLL_READ_SYNC, 32'h0000_0080, 4'hf);
    rdchk(OFS_FLL_VALUE, 32'h1234_5678);
    apb(1'b1, OFS_INTERNAL_RC_CTRL, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFS_FLL_CONTROL, 32'hffff_ffff, 4'h1);
    apb(1'b1, OFS_FLL_MULTIPLIER, 32'hffff_ffff, 4'hc);
    apb(1'b1, OFS_PLL_CONTROL_A, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFS_PLL_OUTPUT_DIVIDER, 32'hffff_ffff, 4'hf);
    rdchk(OFS_PLL_STATUS, 32'h0000_0001);
    chk("rc ctrl", {24'h0, rc_ctl}, MASK_INTERNAL_RC_CTRL);
    chk("fll ctrl", {16'h0, fl_ctl}, 32'h0000_00fe);
    chk("fll mul", fmul, 32'hffff_0000);
    chk("pll ctrl a", {24'h0, pa_ctl}, MASK_PLL_CONTROL_A);
    chk("pll div", {24'h0, pdiv}, MASK_PLL_OUTPUT_DIV);
    chk("pll ratio", prat, MASK_PLL_RATIO);
  endtask : t_lanes
  task automatic t_guard;
    guard <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b1, OFS_IRQ_ENABLE_SET, 32'hffff_ffff, 4'hf);
    apb(1'b1, OFS_PLL_CONTROL_B, 32'hffff_ffff, 4'hf);
    rdchk(OFS_IRQ_ENABLE_SET, 32'h0);
    rdchk(OFS_PLL_CONTROL_B, 32'h0);
    guard <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : t_guard
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, guard} = 4'h0;
    paddr = 8'h0;
    pstrb = 4'h0;
    pwdata = 32'h0;
    src = 32'h0;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    rdchk(OFS_IRQ_FLAGS, 32'h0);
    rdchk(8'h40, 32'h0);
    t_enable();
    t_sources();
    t_lanes();
    t_guard();
    give_verdict();
  end
endmodule : tb_oscillator_ctrl_register_map
`default_nettype wire
